/* File: verilog/task_file_pkg.sv */
// task file constants shared by the device end, the host end and the link
// assumes a single 40 MHz core clock on both ends
// Behaviour
// - data port is 16-bit read/write after reset; the device ignores data writes
// - byte mode only after eight-bit set features
// - error register read-only, valid when not busy
// - diagnostic code lands in error register
// - request sense puts extended code in error
// - sector count zero means 256 sectors
// - sector number: start sector or lba 7:0
// - cylinder low: cylinder low or lba 15:8
// - cylinder high: cylinder high or lba 23:16
// - drive/head picks chs/lba, head or lba 27:24
// - status read-only, other bits invalid while busy
// - status read clears pending interrupt request
// - alternate status same, leaves interrupt alone
// - device control: interrupt enable and soft reset
// - host should not map legacy drive address; the host end blocks reads of it but still forwards writes
// - host loads parameters, then command when ready
// - identify word 59 reports block count one
// - identify words 60-61 give lba capacity
// - identify word 62 reads zero
// - identify word 63 reports multiword dma modes
// - identify word 64 reports pio modes 3 and 4
// - identify words 65-68 report 120 ns
// - identify word 53 marks words valid
package task_file_pkg;
   // task file register selects (cs1/cs0 style: bit 3 = control block)
   localparam logic [3:0] REG_DATA      = 4'h0;
   localparam logic [3:0] REG_ERROR     = 4'h1; // write: features
   localparam logic [3:0] REG_SECCNT    = 4'h2;
   localparam logic [3:0] REG_SECNUM    = 4'h3;
   localparam logic [3:0] REG_CYLLO     = 4'h4;
   localparam logic [3:0] REG_CYLHI     = 4'h5;
   localparam logic [3:0] REG_DRVHEAD   = 4'h6;
   localparam logic [3:0] REG_STATUS    = 4'h7; // write: command
   localparam logic [3:0] REG_ALTSTAT   = 4'he; // write: device control
   localparam logic [3:0] REG_DRVADDR   = 4'hf;
   // status bits
   localparam int ST_BSY  = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DRQ  = 3;
   localparam int ST_ERR  = 0;
   // device control bits, then the drive/head lba bit
   localparam int DC_NIEN = 1;
   localparam int DC_SRST = 2;
   localparam int DH_LBA  = 6;
   // commands and features
   localparam logic [7:0] CMD_DIAG     = 8'h90;
   localparam logic [7:0] CMD_SENSE    = 8'h03;
   localparam logic [7:0] CMD_IDENTIFY = 8'hec;
   localparam logic [7:0] CMD_SETFEAT  = 8'hef;
   localparam logic [7:0] FEAT_8BIT_ON  = 8'h01;
   localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
   localparam logic [7:0] DIAG_PASS    = 8'h01;
   localparam logic [7:0] SENSE_NONE   = 8'h00;
   localparam logic [7:0] ERR_ABORT    = 8'h04;
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [8:0] SECTORS_FULL = 9'h100;
   // identify words
   localparam logic [7:0]  ID_LAST_WORD = 8'hff;
   localparam logic [15:0] ID_W47  = 16'h0001;
   localparam logic [15:0] ID_W49  = 16'h0300;
   localparam logic [15:0] ID_W53  = 16'h0003;
   localparam logic [15:0] ID_W59  = 16'h0101;
   localparam logic [15:0] ID_W62  = 16'h0000;
   localparam logic [15:0] ID_W63  = 16'h0407;
   localparam logic [15:0] ID_W64  = 16'h0003;
   localparam logic [15:0] ID_CYC  = 16'h0078; // 120 ns
   localparam logic [15:0] ID_ZERO = 16'h0000;
   // host command port registers
   localparam logic [3:0] HOST_ADDR_TF   = 4'h0; // +reg select in bits 3:0
   localparam logic [7:0] HOST_CTRL      = 8'hf0; // not decoded anywhere in the host end
   localparam logic [7:0] HOST_STAT      = 8'hf4;
   localparam logic [7:0] HOST_RDATA     = 8'hf8;
endpackage

/* File: verilog/task_file_if.sv */
// task file link between the device end and the host end
// assumes both ends share core_clk; the data bus is modelled as split lanes
`timescale 1ns/1ps
interface task_file_if;
   logic [3:0]  reg_sel;
   logic        rd_stb;
   logic        wr_stb;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        irq;
   modport device (input reg_sel, input rd_stb, input wr_stb,
                   input wdata, output rdata, output irq);
   modport host   (output reg_sel, output rd_stb, output wr_stb,
                   output wdata, input rdata, input irq);
endinterface

/* File: verilog/identify_rom.sv */
// identify parameter word table
// assumes capacity comes in as a parameter of the device
`timescale 1ns/1ps
module identify_rom #(
   parameter logic [31:0] LBA_SECTORS = 32'h0003_d090
) (
   // lookup
   input  wire logic [7:0]  word_idx,
   output logic      [15:0] word_val
);
   import task_file_pkg::*;
   // reserved and unlisted words read as zero; keys are word numbers
   always_comb begin
      case (word_idx)
         8'h2f:   word_val = ID_W47;
         8'h31:   word_val = ID_W49;
         8'h35:   word_val = ID_W53;
         8'h3b:   word_val = ID_W59;
         8'h3c:   word_val = LBA_SECTORS[15:0];
         8'h3d:   word_val = LBA_SECTORS[31:16];
         8'h3e:   word_val = ID_W62;
         8'h3f:   word_val = ID_W63;
         8'h40:   word_val = ID_W64;
         8'h41,
         8'h42,
         8'h43,
         8'h44:   word_val = ID_CYC;
         default: word_val = ID_ZERO;
      endcase
   end
endmodule

/* File: verilog/task_file_device.sv */
// device end of the task file: registers, status, identify stream
// assumes the host strobes are one cycle and synchronous to core_clk
`timescale 1ns/1ps
module task_file_device #(
   parameter logic [31:0] LBA_SECTORS = 32'h0003_d090
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // link
   task_file_if.device      tf,
   // user side
   output logic             byte_mode_q,
   output logic [8:0]       xfer_sectors_q,
   output logic             lba_mode_q,
   output logic [27:0]      start_addr_q,
   output logic             cmd_pulse_q,
   output logic [7:0]       cmd_code_q
);
   import task_file_pkg::*;
   logic [7:0]  features_q, seccnt_q, secnum_q, cyllo_q, cylhi_q;
   logic [7:0]  drvhead_q, status_q, error_q, devctl_q;
   logic        irq_pend_q, id_active_q, byte_hi_q;
   logic [7:0]  id_idx_q;
   logic [15:0] id_word, rdata_d;
   logic        rd, wr, srst;

   assign rd   = tf.rd_stb;
   assign wr   = tf.wr_stb;
   assign srst = devctl_q[DC_SRST];

   identify_rom #(.LBA_SECTORS(LBA_SECTORS)) u_rom (
      .word_idx (id_idx_q),
      .word_val (id_word)
   );

   // parameter registers; soft reset does not clear them
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         features_q <= 8'h00;
         seccnt_q   <= 8'h01;
         secnum_q   <= 8'h01;
         cyllo_q    <= 8'h00;
         cylhi_q    <= 8'h00;
         drvhead_q  <= 8'h00;
         devctl_q   <= 8'h00;
      end else if (wr) begin
         if (tf.reg_sel == REG_ERROR) features_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_SECCNT) seccnt_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_SECNUM) secnum_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_CYLLO) cyllo_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_CYLHI) cylhi_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_DRVHEAD) drvhead_q <= tf.wdata[7:0];
         else if (tf.reg_sel == REG_ALTSTAT) devctl_q <= tf.wdata[7:0];
      end
   end

   // decoded address and count for the media side
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         xfer_sectors_q <= SECTORS_FULL;
         lba_mode_q     <= 1'b0;
         start_addr_q   <= 28'h0;
      end else begin
         xfer_sectors_q <= (seccnt_q == 8'h00) ? SECTORS_FULL
                           : {1'b0, seccnt_q};
         lba_mode_q     <= drvhead_q[DH_LBA];
         // chs: head, cylinder high, cylinder low, sector
         start_addr_q   <= {drvhead_q[3:0], cylhi_q, cyllo_q,
                            secnum_q};
      end
   end

   // command execution: one cycle per command; identify then holds drq for its data
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_q    <= STATUS_RESET;
         error_q     <= DIAG_PASS;
         byte_mode_q <= 1'b0;
         cmd_pulse_q <= 1'b0;
         cmd_code_q  <= 8'h00;
         id_active_q <= 1'b0;
      end else if (srst) begin
         // soft reset holds the device busy until released
         status_q    <= 8'h80;
         error_q     <= DIAG_PASS;
         byte_mode_q <= 1'b0;
         cmd_pulse_q <= 1'b0;
         id_active_q <= 1'b0;
      end else begin
         cmd_pulse_q <= 1'b0;
         if (status_q[ST_BSY]) status_q <= STATUS_RESET;
         if (wr && tf.reg_sel == REG_STATUS) begin
            cmd_pulse_q <= 1'b1;
            cmd_code_q  <= tf.wdata[7:0];
            status_q    <= STATUS_RESET;
            id_active_q <= 1'b0;
            if (tf.wdata[7:0] == CMD_DIAG) begin
               error_q <= DIAG_PASS;
            end else if (tf.wdata[7:0] == CMD_SENSE) begin
               error_q <= SENSE_NONE;
            end else if (tf.wdata[7:0] == CMD_IDENTIFY) begin
               error_q     <= 8'h00;
               id_active_q <= 1'b1;
               status_q[ST_DRQ] <= 1'b1;
            end else if (tf.wdata[7:0] == CMD_SETFEAT) begin
               error_q <= 8'h00;
               if (features_q == FEAT_8BIT_ON) byte_mode_q <= 1'b1;
               else if (features_q == FEAT_8BIT_OFF) byte_mode_q <= 1'b0;
            end else begin
               error_q <= 8'h00;
            end
         end else if (id_active_q && rd && tf.reg_sel == REG_DATA &&
                      id_idx_q == ID_LAST_WORD &&
                      (!byte_mode_q || byte_hi_q)) begin
            id_active_q      <= 1'b0;
            status_q[ST_DRQ] <= 1'b0;
         end
      end
   end

   // identify word pointer; byte mode takes two reads per word
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         id_idx_q  <= 8'h00;
         byte_hi_q <= 1'b0;
      end else if (wr && tf.reg_sel == REG_STATUS) begin
         id_idx_q  <= 8'h00;
         byte_hi_q <= 1'b0;
      end else if (id_active_q && rd && tf.reg_sel == REG_DATA) begin
         if (byte_mode_q && !byte_hi_q) begin
            byte_hi_q <= 1'b1;
         end else begin
            byte_hi_q <= 1'b0;
            id_idx_q  <= id_idx_q + 8'h01;
         end
      end
   end

   // interrupt: raised on command completion, cleared by status read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_pend_q <= 1'b0;
      end else if (wr && tf.reg_sel == REG_STATUS) begin
         irq_pend_q <= 1'b1;     // set wins over a same-cycle clear
      end else if (rd && tf.reg_sel == REG_STATUS) begin
         irq_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) tf.irq <= 1'b0;
      else     tf.irq <= irq_pend_q & ~devctl_q[DC_NIEN];
   end

   // read data stands in the cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (tf.reg_sel == REG_DATA) begin
         if (!id_active_q) rdata_d = 16'h0000;
         else if (!byte_mode_q) rdata_d = id_word;
         else if (byte_hi_q) rdata_d = {8'h00, id_word[15:8]};
         else rdata_d = {8'h00, id_word[7:0]};
      end
      else if (tf.reg_sel == REG_ERROR) rdata_d = {8'h00, error_q};
      else if (tf.reg_sel == REG_SECCNT) rdata_d = {8'h00, seccnt_q};
      else if (tf.reg_sel == REG_SECNUM) rdata_d = {8'h00, secnum_q};
      else if (tf.reg_sel == REG_CYLLO) rdata_d = {8'h00, cyllo_q};
      else if (tf.reg_sel == REG_CYLHI) rdata_d = {8'h00, cylhi_q};
      else if (tf.reg_sel == REG_DRVHEAD) rdata_d = {8'h00, drvhead_q};
      else if (tf.reg_sel == REG_STATUS ||
               tf.reg_sel == REG_ALTSTAT)
         rdata_d = {8'h00, status_q};
      else if (tf.reg_sel == REG_DRVADDR)
         rdata_d = {8'h00, 1'b1, 1'b1, ~drvhead_q[3:0], 2'b10};
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)     tf.rdata <= 16'h0000;
      else if (rd) tf.rdata <= rdata_d;
   end
endmodule

/* File: verilog/task_file_host.sv */
// host end: turns command-port requests into single task file cycles
// assumes the device answers a read one cycle after its strobe
`timescale 1ns/1ps
module task_file_host (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // command port
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata_q,
   // link
   task_file_if.host        tf
);
   import task_file_pkg::*;
   logic        pend_rd_q;
   logic [15:0] last_q;

   // addr 0x00-0x0f passes straight to the task file; reads of 0xf are blocked
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tf.reg_sel <= 4'h0;
         tf.rd_stb  <= 1'b0;
         tf.wr_stb  <= 1'b0;
         tf.wdata   <= 16'h0000;
      end else begin
         tf.reg_sel <= addr[3:0];
         tf.wdata   <= wdata;
         tf.wr_stb  <= wr && addr[7:4] == HOST_ADDR_TF;
         tf.rd_stb  <= rd && addr[7:4] == HOST_ADDR_TF &&
                       addr[3:0] != REG_DRVADDR;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) pend_rd_q <= 1'b0;
      else     pend_rd_q <= tf.rd_stb;
   end

   // software orders writes the port only forwards them
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)            last_q <= 16'h0000;
      else if (pend_rd_q) last_q <= tf.rdata;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rdata_q <= 16'h0000;
      else if (rd && addr == HOST_RDATA) rdata_q <= last_q;
      else if (rd && addr == HOST_STAT) rdata_q <= {15'h0000, tf.irq};
      else rdata_q <= 16'h0000;
   end
endmodule

/* File: verification/task_file_checker.sv */
// link checker for the task file: irq, status and error answers
// assumes the device and host ends face each other on one core_clk
`timescale 1ns/1ps
module task_file_checker
   import task_file_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // link
   input  wire logic [3:0]  reg_sel,
   input  wire logic        rd_stb,
   input  wire logic        wr_stb,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        irq
);
   logic       nien_q;
   logic       srst_q;
   logic       err_vld_q;
   logic [7:0] err_exp_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // device control bits as last written over the link
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         nien_q <= 1'h0;
         srst_q <= 1'h0;
      end else if (wr_stb && reg_sel == REG_ALTSTAT) begin
         nien_q <= wdata[DC_NIEN];
         srst_q <= wdata[DC_SRST];
      end
   end

   // expected error code; only diag and sense give a known one
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         err_vld_q <= 1'h0;
         err_exp_q <= 8'h00;
      end else if (wr_stb && reg_sel == REG_STATUS) begin
         err_vld_q <= wdata[7:0] == CMD_DIAG || wdata[7:0] == CMD_SENSE;
         err_exp_q <= (wdata[7:0] == CMD_DIAG) ? DIAG_PASS : SENSE_NONE;
      end else if (wr_stb && reg_sel == REG_ALTSTAT && wdata[DC_SRST]) begin
         err_vld_q <= 1'h0;
      end
   end

   sequence alt_rd_s;  rd_stb && reg_sel == REG_ALTSTAT; endsequence
   sequence stat_rd_s; rd_stb && reg_sel == REG_STATUS;  endsequence
   sequence cmd_wr_s;  wr_stb && reg_sel == REG_STATUS;  endsequence

   // irq passes a pending flop and then the pin flop, so it moves two
   // edges after the strobe that sets or clears it
   irq_clear_a: assert property (stat_rd_s |-> ##2 !irq)
      else $error("status read left irq set");
   altstat_keep_a: assert property (alt_rd_s ##0 irq |=> irq)
      else $error("alternate status read dropped irq");
   irq_raise_a: assert property (cmd_wr_s ##0 !nien_q ##0 !srst_q
      |-> ##2 irq)
      else $error("command write did not raise irq");
   irq_mask_a: assert property (nien_q && $past(nien_q)
      && $past(nien_q, 2) |-> !irq)
      else $error("irq seen while disabled");
   alt_match_a: assert property (alt_rd_s ##1 stat_rd_s
      |=> rdata[7:0] == $past(rdata[7:0]))
      else $error("alternate status differs from status");
   srst_busy_a: assert property (stat_rd_s
      ##0 (srst_q && $past(srst_q)) |=> rdata[ST_BSY])
      else $error("status not busy during soft reset");
   err_code_a: assert property (rd_stb && reg_sel == REG_ERROR
      && err_vld_q |=> rdata[7:0] == err_exp_q)
      else $error("wrong code in error register");
   no_drvaddr_a: assert property (!(rd_stb && reg_sel == REG_DRVADDR))
      else $error("host read the legacy drive address");
endmodule

/* File: verification/test_ata_task_file_regs.sv */
// self-checking bench: host end and device end joined by the link
// assumes the host command port answers one cycle after its read strobe
`timescale 1ns/1ps
module test_ata_task_file_regs;
   import task_file_pkg::*;
   localparam logic [31:0] LBA_N = 32'h0001_2345;
   logic        core_clk;
   logic        rst;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata_q;
   logic        byte_mode_q;
   logic [8:0]  xfer_sectors_q;
   logic        lba_mode_q;
   logic [27:0] start_addr_q;
   logic        cmd_pulse_q;
   logic [7:0]  cmd_code_q;
   logic [15:0] rv;
   logic [16:0] ew;
   int          n_fail;
   int          checks_done;
   int          n_pulse = 0;

   task_file_if i_task_file_if ();
   task_file_device #(.LBA_SECTORS(LBA_N)) i_task_file_device (
      .core_clk(core_clk), .rst(rst), .tf(i_task_file_if),
      .byte_mode_q(byte_mode_q), .xfer_sectors_q(xfer_sectors_q),
      .lba_mode_q(lba_mode_q), .start_addr_q(start_addr_q),
      .cmd_pulse_q(cmd_pulse_q), .cmd_code_q(cmd_code_q));
   task_file_host i_task_file_host (
      .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_q(rdata_q), .tf(i_task_file_if));
   task_file_checker i_task_file_checker (
      .core_clk(core_clk), .rst(rst), .reg_sel(i_task_file_if.reg_sel),
      .rd_stb(i_task_file_if.rd_stb), .wr_stb(i_task_file_if.wr_stb),
      .wdata(i_task_file_if.wdata), .rdata(i_task_file_if.rdata),
      .irq(i_task_file_if.irq));

   // free-running core clock, 25 ns period
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   // count command pulses on the user side; each must last one cycle
   always @(posedge core_clk) begin
      if (cmd_pulse_q) n_pulse <= n_pulse + 1;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one write strobe, then room for the link and the device to act
   task automatic hw(input logic [3:0] r, input logic [15:0] d);
      @(posedge core_clk);
      addr  <= {4'h0, r};
      wdata <= d;
      wr    <= 1'h1;
      @(posedge core_clk);
      wr <= 1'h0;
      repeat (3) @(posedge core_clk);
   endtask

   // one read strobe on the command port; data stand in the next cycle
   task automatic rd1(input logic [7:0] a);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge core_clk);
      rd <= 1'h0;
      #1 rv = rdata_q;
   endtask

   // task file read: link cycle first, then fetch what it returned
   task automatic tr(input logic [3:0] r);
      rd1({4'h0, r});
      repeat (2) @(posedge core_clk);
      rd1(HOST_RDATA);
   endtask

   task automatic irq_is(input logic e);
      rd1(HOST_STAT);
      chk({15'h0000, rv[0]}, {15'h0000, e});
   endtask

   // alternate status then status with no gap between the strobes
   task automatic b2b();
      @(posedge core_clk);
      addr <= {4'h0, REG_ALTSTAT};
      rd   <= 1'h1;
      @(posedge core_clk);
      addr <= {4'h0, REG_STATUS};
      @(posedge core_clk);
      rd <= 1'h0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic t_reset();
      tr(REG_STATUS);
      chk(rv[7:0], STATUS_RESET);
      tr(REG_ERROR);
      chk(rv[7:0], DIAG_PASS);
      chk(byte_mode_q, 1'h0);
      irq_is(1'h0);
      $display("test reset done");
   endtask

   task automatic t_params();
      hw(REG_SECCNT, 16'h0000);
      hw(REG_SECNUM, 16'h0012);
      hw(REG_CYLLO, 16'h0034);
      hw(REG_CYLHI, 16'h0056);
      hw(REG_DRVHEAD, 16'h0047);
      hw(REG_STATUS, {8'h00, CMD_DIAG});
      chk(xfer_sectors_q, SECTORS_FULL);
      chk(lba_mode_q, 1'h1);
      chk(start_addr_q[15:0], 16'h3412);
      chk(start_addr_q[27:16], 12'h756);
      tr(REG_SECNUM);
      chk(rv[7:0], 8'h12);
      hw(REG_SECCNT, 16'h00ff);
      hw(REG_DRVHEAD, 16'h0003);
      hw(REG_STATUS, {8'h00, CMD_DIAG});
      chk(xfer_sectors_q, 9'h0ff);
      chk({lba_mode_q, start_addr_q[27:24]}, 5'h03);
      $display("test params done");
   endtask

   task automatic t_cmds();
      int pc;
      hw(REG_STATUS, {8'h00, CMD_DIAG});
      irq_is(1'h1);
      tr(REG_ALTSTAT);
      chk(rv[7:0], STATUS_RESET);
      irq_is(1'h1);
      tr(REG_STATUS);
      irq_is(1'h0);
      tr(REG_ERROR);
      chk(rv[7:0], DIAG_PASS);
      pc = n_pulse;
      hw(REG_STATUS, {8'h00, CMD_SENSE});
      chk(16'(n_pulse - pc), 16'h0001);
      tr(REG_ERROR);
      chk(rv[7:0], SENSE_NONE);
      chk(cmd_code_q, CMD_SENSE);
      $display("test commands done");
   endtask

   task automatic t_devctl();
      hw(REG_ALTSTAT, 16'h0002);
      hw(REG_STATUS, {8'h00, CMD_DIAG});
      irq_is(1'h0);
      hw(REG_ALTSTAT, 16'h0004);
      tr(REG_STATUS);
      chk(rv[ST_BSY], 1'h1);
      b2b();
      hw(REG_ALTSTAT, 16'h0000);
      tr(REG_STATUS);
      chk(rv[ST_BSY], 1'h0);
      $display("test device control done");
   endtask

   task automatic t_ident();
      hw(REG_STATUS, {8'h00, CMD_IDENTIFY});
      tr(REG_STATUS);
      chk(rv[ST_DRQ], 1'h1);
      b2b();
      for (int i = 0; i < 256; i++) begin
         tr(REG_DATA);
         case (i)
            53: ew = {1'h1, ID_W53};
            59: ew = {1'h1, ID_W59};
            60: ew = {1'h1, LBA_N[15:0]};
            61: ew = {1'h1, LBA_N[31:16]};
            62: ew = {1'h1, ID_W62};
            63: ew = {1'h1, ID_W63};
            64: ew = {1'h1, ID_W64};
            65, 66, 67, 68: ew = {1'h1, ID_CYC};
            default: ew = {i > 68, ID_ZERO};
         endcase
         if (ew[16])
            chk(rv, ew[15:0]);
      end
      tr(REG_STATUS);
      chk(rv[ST_DRQ], 1'h0);
      $display("test identify done");
   endtask

   task automatic t_byte();
      logic [15:0] lo;
      hw(REG_ERROR, {8'h00, FEAT_8BIT_ON});
      chk(byte_mode_q, 1'h0);
      hw(REG_STATUS, {8'h00, CMD_SETFEAT});
      chk(byte_mode_q, 1'h1);
      // byte mode: each identify word comes as low byte, then high byte
      hw(REG_STATUS, {8'h00, CMD_IDENTIFY});
      for (int w = 0; w < 64; w++) begin
         tr(REG_DATA);
         lo = rv;
         tr(REG_DATA);
         if (w == 53 || w == 63) begin
            ew = (w == 53) ? {1'h1, ID_W53} : {1'h1, ID_W63};
            chk(lo, {8'h00, ew[7:0]});
            chk(rv, {8'h00, ew[15:8]});
         end
      end
      tr(REG_DRVADDR);
      hw(REG_ERROR, {8'h00, FEAT_8BIT_OFF});
      hw(REG_STATUS, {8'h00, CMD_SETFEAT});
      chk(byte_mode_q, 1'h0);
      $display("test byte mode done");
   endtask

   // cut a hang short
   initial begin
      repeat (50000) @(posedge core_clk);
      n_fail++;
      conclude();
   end

   // main sequence
   initial begin
      n_fail = 0;
      checks_done = 0;
      rst = 1'h1;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'h0;
      rd = 1'h0;
      repeat (6) @(posedge core_clk);
      rst <= 1'h0;
      t_reset();
      t_params();
      t_cmds();
      t_devctl();
      t_ident();
      t_byte();
      conclude();
   end
endmodule
